// >>> pkg/adc_sys_map.svh
/*
 Opcodes, register field positions, reset values and timing counts for the
 converter and system instruction executor.
 Assumes it is included by its bare name from design files.
*/
`ifndef ADC_SYS_MAP_SVH
`define ADC_SYS_MAP_SVH

// ************************************************************
// Opcodes (10-bit instruction words)
// ************************************************************
`define OP_READ_RESULT     10'h279
`define OP_READ_LOW_RESULT 10'h249
`define OP_WRITE_REF       10'h239
`define OP_READ_CONV_CTRL  10'h244
`define OP_WRITE_CONV_CTRL 10'h204
`define OP_CONV_START      10'h29F
`define OP_POLL_DONE       10'h287
`define OP_NO_OPERATION    10'h000
`define OP_BACKUP_ENTER    10'h008
`define OP_BACKUP_ARM      10'h05B
`define OP_TEST_STANDBY    10'h003
`define OP_WDT_STOP_ARM    10'h29C
`define OP_WDT_RESTART     10'h2A0
`define OP_SEL_CERAMIC     10'h29A
`define OP_SEL_RC          10'h29B
`define OP_READ_CLK_CTRL   10'h252
`define OP_WRITE_CLK_CTRL  10'h216

// ************************************************************
// Field positions
// ************************************************************
`define CONV_MODE_SELECT_POS  3
`define POLL_DISABLE_POS      2

// ************************************************************
// Reset values
// ************************************************************
`define CONV_CTRL_RESET   4'h0
`define CLK_CTRL_RESET    4'h0
`define CMP_REF_RESET     8'h00
`define CLK_SRC_RESET     1'b0

// ************************************************************
// Timing counts
// ************************************************************
`define EXEC_LATENCY_CYCLES 1

`endif

// >>> pkg/adc_sys_pkg.sv
/*
 Types shared by the executor: arming state and clock source.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_sys_pkg;

  // ************************************************************
  // Arming state of the one-shot prefix instructions
  // ************************************************************
  typedef enum logic [2:0] {
    ARM_NONE   = 3'b001,
    ARM_BACKUP = 3'b010,
    ARM_WDT    = 3'b100
  } arm_state_t;

  typedef enum logic {
    CLK_SRC_CERAMIC = 1'b0,
    CLK_SRC_RC      = 1'b1
  } clk_src_t;

endpackage : adc_sys_pkg

// >>> verilog/flag_cell.sv
/*
 One hardware-set, instruction-cleared flag; a set beats a clear.
 Assumes set and clear come from logic on the same clock.
*/
module flag_cell (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  logic flag_ff;
  logic nxt_flag;

  always_comb
  begin
    nxt_flag = flag_ff;
    if (clr)
    begin
      nxt_flag = 1'b0;
    end
    if (set)
    begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

endmodule : flag_cell

// >>> verilog/adc_sys_exec.sv
/*
 Executor for converter and system instructions of a 4-bit core.
 Assumes the core presents one decoded word per instr_valid pulse, all
 inputs come from logic on clk, and the core applies the register writes
 and the skip one cycle after the pulse.
*/
// What this block does
// - Conversion mode result read: upper four bits to B, middle four to A.
// - Comparator mode result read: reference upper nibble to B, lower to A.
// - Low result read puts the two lowest result bits in A bits 3 and 2.
// - Reference write loads B:A in comparator mode, does nothing in conversion.
// - Instructions read and write the converter control register through A.
// - Control bit 3 picks conversion (0) or comparator (1) mode.
// - Start clears the done flag and starts conversion or comparison by mode.
// - Poll enabled: skip and clear when done flag set, else continue.
// - Poll disabled: the completion test does nothing.
// - Poll disable is bit 2 of interrupt control register two.
// - No operation only advances the program counter by one.
// - Backup entry halts instruction execution until reset, but only right after the arm instruction.
// - Backup arm validates only the immediately following entry instruction.
// - Standby flag test skips when flag is 1, flag kept.
// - Watchdog restart skips and clears when expiry flag set.
// - Watchdog stops when restart directly follows the stop arm instruction.
// - Ceramic select switches to ceramic resonator, stops on-chip oscillator.
// - RC select switches to RC circuit, stops on-chip oscillator.
// - Instructions read and write the clock control register through A.
`include "adc_sys_map.svh"

module adc_sys_exec (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       instr_valid,
  input  wire logic [9:0] instr_word,
  input  wire logic [3:0] acc_in,
  input  wire logic [3:0] breg_in,
  input  wire logic [9:0] conv_result,
  input  wire logic       conv_complete,
  input  wire logic [3:0] interrupt_control_reg_two,
  input  wire logic       standby_return_flag,
  input  wire logic       watchdog_expiry,
  output logic            acc_wr_en,
  output logic [3:0]      acc_wr_data,
  output logic            breg_wr_en,
  output logic [3:0]      breg_wr_data,
  output logic            instr_done,
  output logic            skip_next,
  output logic [3:0]      conversion_control_register,
  output logic            conversion_mode_select_bit,
  output logic [7:0]      cmp_ref,
  output logic            conv_start,
  output logic            cmp_start,
  output logic            conversion_done_flag,
  output logic            watchdog_expiry_flag,
  output logic            watchdog_running,
  output logic            watchdog_restart,
  output logic            backup_state,
  output logic [3:0]      clock_control_register,
  output logic            clk_src_rc,
  output logic            onchip_osc_stopped
);

  // ************************************************************
  // State
  // ************************************************************
  logic                    acc_wr_en_ff;
  logic                    nxt_acc_wr_en;
  logic [3:0]              acc_wr_data_ff;
  logic [3:0]              nxt_acc_wr_data;
  logic                    breg_wr_en_ff;
  logic                    nxt_breg_wr_en;
  logic [3:0]              breg_wr_data_ff;
  logic [3:0]              nxt_breg_wr_data;
  logic                    done_ff;
  logic                    nxt_done;
  logic                    skip_ff;
  logic                    nxt_skip;
  logic [3:0]              conv_ctrl_ff;
  logic [3:0]              nxt_conv_ctrl;
  logic [7:0]              cmp_ref_ff;
  logic [7:0]              nxt_cmp_ref;
  logic                    conv_start_ff;
  logic                    nxt_conv_start;
  logic                    cmp_start_ff;
  logic                    nxt_cmp_start;
  logic                    wdt_run_ff;
  logic                    nxt_wdt_run;
  logic                    wdt_restart_ff;
  logic                    nxt_wdt_restart;
  logic                    backup_ff;
  logic                    nxt_backup;
  logic [3:0]              clk_ctrl_ff;
  logic [3:0]              nxt_clk_ctrl;
  adc_sys_pkg::clk_src_t   clk_src_ff;
  adc_sys_pkg::clk_src_t   nxt_clk_src;
  logic                    osc_stop_ff;
  logic                    nxt_osc_stop;
  adc_sys_pkg::arm_state_t arm_ff;
  adc_sys_pkg::arm_state_t nxt_arm;

  logic                    exec;
  logic                    cmp_mode;
  logic                    poll_off;
  logic [1:0]              flag_set;
  logic [1:0]              flag_clr;
  logic [1:0]              flag_q;

  // Backup state halts the executor until reset
  assign exec     = instr_valid && !backup_ff;
  assign cmp_mode = conv_ctrl_ff[`CONV_MODE_SELECT_POS];
  assign poll_off = interrupt_control_reg_two[`POLL_DISABLE_POS];

  // ************************************************************
  // Completion and watchdog expiry flags
  // ************************************************************
  assign flag_set[0] = conv_complete;
  assign flag_set[1] = watchdog_expiry;
  assign flag_clr[0] = exec && ((instr_word == `OP_CONV_START)
                       || (instr_word == `OP_POLL_DONE && !poll_off && flag_q[0]));
  assign flag_clr[1] = exec && instr_word == `OP_WDT_RESTART && flag_q[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flag
      flag_cell u_flag (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (flag_set[gi]),
        .clr   (flag_clr[gi]),
        .flag  (flag_q[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    nxt_acc_wr_en    = 1'b0;
    nxt_acc_wr_data  = acc_wr_data_ff;
    nxt_breg_wr_en   = 1'b0;
    nxt_breg_wr_data = breg_wr_data_ff;
    nxt_done         = exec;
    nxt_skip         = 1'b0;
    nxt_conv_ctrl    = conv_ctrl_ff;
    nxt_cmp_ref      = cmp_ref_ff;
    nxt_conv_start   = 1'b0;
    nxt_cmp_start    = 1'b0;
    nxt_wdt_run      = wdt_run_ff;
    nxt_wdt_restart  = 1'b0;
    nxt_backup       = backup_ff;
    nxt_clk_ctrl     = clk_ctrl_ff;
    nxt_clk_src      = clk_src_ff;
    nxt_osc_stop     = osc_stop_ff;
    nxt_arm          = arm_ff;
    if (exec)
    begin
      // Any word consumes a pending arm; the arm words re-arm below
      nxt_arm = adc_sys_pkg::ARM_NONE;
      unique case (instr_word)
        `OP_READ_RESULT:
        begin
          nxt_acc_wr_en  = 1'b1;
          nxt_breg_wr_en = 1'b1;
          if (cmp_mode)
          begin
            nxt_breg_wr_data = cmp_ref_ff[7:4];
            nxt_acc_wr_data  = cmp_ref_ff[3:0];
          end
          else
          begin
            nxt_breg_wr_data = conv_result[9:6];
            nxt_acc_wr_data  = conv_result[5:2];
          end
        end
        `OP_READ_LOW_RESULT:
        begin
          nxt_acc_wr_en   = 1'b1;
          nxt_acc_wr_data = {conv_result[1:0], 2'b00};
        end
        `OP_WRITE_REF:
        begin
          if (cmp_mode)
          begin
            nxt_cmp_ref = {breg_in, acc_in};
          end
        end
        `OP_READ_CONV_CTRL:
        begin
          nxt_acc_wr_en   = 1'b1;
          nxt_acc_wr_data = conv_ctrl_ff;
        end
        `OP_WRITE_CONV_CTRL:
        begin
          nxt_conv_ctrl = acc_in;
        end
        `OP_CONV_START:
        begin
          nxt_conv_start = !cmp_mode;
          nxt_cmp_start  = cmp_mode;
        end
        `OP_POLL_DONE:
        begin
          nxt_skip = !poll_off && flag_q[0];
        end
        `OP_NO_OPERATION:
        begin
          nxt_skip = 1'b0;
        end
        `OP_BACKUP_ENTER:
        begin
          if (arm_ff == adc_sys_pkg::ARM_BACKUP)
          begin
            nxt_backup = 1'b1;
          end
        end
        `OP_BACKUP_ARM:
        begin
          nxt_arm = adc_sys_pkg::ARM_BACKUP;
        end
        `OP_TEST_STANDBY:
        begin
          nxt_skip = standby_return_flag;
        end
        `OP_WDT_STOP_ARM:
        begin
          nxt_arm = adc_sys_pkg::ARM_WDT;
        end
        `OP_WDT_RESTART:
        begin
          nxt_skip        = flag_q[1];
          nxt_wdt_restart = 1'b1;
          if (arm_ff == adc_sys_pkg::ARM_WDT)
          begin
            nxt_wdt_run = 1'b0;
          end
        end
        `OP_SEL_CERAMIC:
        begin
          nxt_clk_src  = adc_sys_pkg::CLK_SRC_CERAMIC;
          nxt_osc_stop = 1'b1;
        end
        `OP_SEL_RC:
        begin
          nxt_clk_src  = adc_sys_pkg::CLK_SRC_RC;
          nxt_osc_stop = 1'b1;
        end
        `OP_READ_CLK_CTRL:
        begin
          nxt_acc_wr_en   = 1'b1;
          nxt_acc_wr_data = clk_ctrl_ff;
        end
        `OP_WRITE_CLK_CTRL:
        begin
          nxt_clk_ctrl = acc_in;
        end
        default:
        begin
          // Words owned by other executors: no done pulse, but a pending arm is still consumed
          nxt_done = 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_wr_en_ff    <= 1'b0;
      acc_wr_data_ff  <= 4'h0;
      breg_wr_en_ff   <= 1'b0;
      breg_wr_data_ff <= 4'h0;
      done_ff         <= 1'b0;
      skip_ff         <= 1'b0;
      conv_ctrl_ff    <= `CONV_CTRL_RESET;
      cmp_ref_ff      <= `CMP_REF_RESET;
      conv_start_ff   <= 1'b0;
      cmp_start_ff    <= 1'b0;
      wdt_run_ff      <= 1'b1;
      wdt_restart_ff  <= 1'b0;
      backup_ff       <= 1'b0;
      clk_ctrl_ff     <= `CLK_CTRL_RESET;
      clk_src_ff      <= adc_sys_pkg::CLK_SRC_CERAMIC;
      osc_stop_ff     <= 1'b0;
      arm_ff          <= adc_sys_pkg::ARM_NONE;
    end
    else
    begin
      acc_wr_en_ff    <= nxt_acc_wr_en;
      acc_wr_data_ff  <= nxt_acc_wr_data;
      breg_wr_en_ff   <= nxt_breg_wr_en;
      breg_wr_data_ff <= nxt_breg_wr_data;
      done_ff         <= nxt_done;
      skip_ff         <= nxt_skip;
      conv_ctrl_ff    <= nxt_conv_ctrl;
      cmp_ref_ff      <= nxt_cmp_ref;
      conv_start_ff   <= nxt_conv_start;
      cmp_start_ff    <= nxt_cmp_start;
      wdt_run_ff      <= nxt_wdt_run;
      wdt_restart_ff  <= nxt_wdt_restart;
      backup_ff       <= nxt_backup;
      clk_ctrl_ff     <= nxt_clk_ctrl;
      clk_src_ff      <= nxt_clk_src;
      osc_stop_ff     <= nxt_osc_stop;
      arm_ff          <= nxt_arm;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign acc_wr_en                   = acc_wr_en_ff;
  assign acc_wr_data                 = acc_wr_data_ff;
  assign breg_wr_en                  = breg_wr_en_ff;
  assign breg_wr_data                = breg_wr_data_ff;
  assign instr_done                  = done_ff;
  assign skip_next                   = skip_ff;
  assign conversion_control_register = conv_ctrl_ff;
  assign conversion_mode_select_bit  = cmp_mode;
  assign cmp_ref                     = cmp_ref_ff;
  assign conv_start                  = conv_start_ff;
  assign cmp_start                   = cmp_start_ff;
  assign conversion_done_flag        = flag_q[0];
  assign watchdog_expiry_flag        = flag_q[1];
  assign watchdog_running            = wdt_run_ff;
  assign watchdog_restart            = wdt_restart_ff;
  assign backup_state                = backup_ff;
  assign clock_control_register      = clk_ctrl_ff;
  assign clk_src_rc                  = (clk_src_ff == adc_sys_pkg::CLK_SRC_RC);
  assign onchip_osc_stopped          = osc_stop_ff;

endmodule : adc_sys_exec

// >>> test/adc_conv_model.sv
/*
 Behavioural converter and comparator on the far side of the executor.
 Assumes start pulses are one cycle long and arrive on clk.
*/
module adc_conv_model #(
  parameter int         BUSY_CYCLES = 6,
  parameter logic [9:0] RESULT_VAL  = 10'h2D6
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       conv_start,
  input  wire logic       cmp_start,
  output logic            conv_complete,
  output logic [9:0]      conv_result
);
  timeunit 1ns;
  timeprecision 1ns;

  int busy_ff;

  assign conv_result = RESULT_VAL;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      busy_ff       <= 0;
      conv_complete <= 1'b0;
    end
    else
    begin
      conv_complete <= (busy_ff == 1);
      if (conv_start || cmp_start)
        busy_ff <= BUSY_CYCLES;
      else if (busy_ff != 0)
        busy_ff <= busy_ff - 1;
    end
endmodule : adc_conv_model

// >>> test/adc_sys_exec_props.sv
/*
 Port assertions for the instruction executor.
 Assumes the map header is on the include path; bound to adc_sys_exec.
*/
`include "adc_sys_map.svh"
module adc_sys_exec_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] breg_in,
  input wire logic [9:0] conv_result,
  input wire logic       conv_complete,
  input wire logic [3:0] interrupt_control_reg_two,
  input wire logic       standby_return_flag,
  input wire logic       watchdog_expiry,
  input wire logic       acc_wr_en,
  input wire logic [3:0] acc_wr_data,
  input wire logic       breg_wr_en,
  input wire logic [3:0] breg_wr_data,
  input wire logic       instr_done,
  input wire logic       skip_next,
  input wire logic [3:0] conversion_control_register,
  input wire logic       conversion_mode_select_bit,
  input wire logic [7:0] cmp_ref,
  input wire logic       conv_start,
  input wire logic       cmp_start,
  input wire logic       conversion_done_flag,
  input wire logic       watchdog_expiry_flag,
  input wire logic       watchdog_running,
  input wire logic       watchdog_restart,
  input wire logic       backup_state,
  input wire logic [3:0] clock_control_register,
  input wire logic       clk_src_rc,
  input wire logic       onchip_osc_stopped
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       go;
  logic [9:0] res_ff;
  logic [3:0] acc_ff;
  logic [3:0] b_ff;
  logic       bk_arm_ff;
  logic       wd_arm_ff;
  logic       nxt_bk_arm;
  logic       nxt_wd_arm;

  assign go = instr_valid && !backup_state;

  // Any word consumes a pending arm
  always_comb
  begin
    nxt_bk_arm = instr_valid ? (instr_word == `OP_BACKUP_ARM) : bk_arm_ff;
    nxt_wd_arm = instr_valid ? (instr_word == `OP_WDT_STOP_ARM) : wd_arm_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      bk_arm_ff <= 1'b0;
      wd_arm_ff <= 1'b0;
    end
    else
    begin
      bk_arm_ff <= nxt_bk_arm;
      wd_arm_ff <= nxt_wd_arm;
    end

  always_ff @(posedge clk)
  begin
    res_ff <= conv_result;
    acc_ff <= acc_in;
    b_ff   <= breg_in;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_read_conv_mode: assert property (go && instr_word == `OP_READ_RESULT &&
    !conversion_mode_select_bit |=> acc_wr_en && breg_wr_en &&
    breg_wr_data == res_ff[9:6] && acc_wr_data == res_ff[5:2]) else $error("result read bad");
  a_read_cmp_mode: assert property (go && instr_word == `OP_READ_RESULT &&
    conversion_mode_select_bit |=> breg_wr_data == cmp_ref[7:4] && acc_wr_data == cmp_ref[3:0])
    else $error("reference read bad");
  a_low_read: assert property (go && instr_word == `OP_READ_LOW_RESULT |=> acc_wr_en &&
    !breg_wr_en && acc_wr_data == {res_ff[1:0], 2'b00}) else $error("low read bad");
  a_ref_write: assert property (go && instr_word == `OP_WRITE_REF |=> !acc_wr_en &&
    cmp_ref == ($past(conversion_mode_select_bit) ? {b_ff, acc_ff} : $past(cmp_ref)))
    else $error("reference write bad");
  a_ctrl_access: assert property (go && instr_word == `OP_WRITE_CONV_CTRL |=>
    conversion_control_register == acc_ff && conversion_mode_select_bit == acc_ff[3])
    else $error("control write bad");
  a_start_by_mode: assert property (go && instr_word == `OP_CONV_START &&
    !conv_complete |=>
    !conversion_done_flag && cmp_start == conversion_mode_select_bit && conv_start != cmp_start)
    else $error("start bad");
  a_poll_skip: assert property (go && instr_word == `OP_POLL_DONE &&
    !interrupt_control_reg_two[2] && !conv_complete |=> instr_done &&
    skip_next == $past(conversion_done_flag) && !conversion_done_flag) else $error("poll bad");
  a_poll_off: assert property (go && instr_word == `OP_POLL_DONE &&
    interrupt_control_reg_two[2] && !conv_complete |=> !skip_next &&
    conversion_done_flag == $past(conversion_done_flag)) else $error("poll off bad");
  a_nop_quiet: assert property (go && instr_word == `OP_NO_OPERATION |=> instr_done &&
    !acc_wr_en && !breg_wr_en && !skip_next && $stable(cmp_ref)) else $error("nop bad");
  a_backup_armed: assert property (go && instr_word == `OP_BACKUP_ENTER |=>
    backup_state == $past(bk_arm_ff)) else $error("backup entry bad");
  a_standby_skip: assert property (go && instr_word == `OP_TEST_STANDBY |=>
    skip_next == $past(standby_return_flag)) else $error("standby test bad");
  a_wdt_restart: assert property (go && instr_word == `OP_WDT_RESTART &&
    !watchdog_expiry |=>
    watchdog_restart && skip_next == $past(watchdog_expiry_flag) && !watchdog_expiry_flag)
    else $error("restart bad");
  a_wdt_stop: assert property (go && instr_word == `OP_WDT_RESTART && wd_arm_ff |=>
    !watchdog_running) else $error("watchdog stop bad");
  a_src_select: assert property (go && (instr_word == `OP_SEL_RC ||
    instr_word == `OP_SEL_CERAMIC) |=> onchip_osc_stopped &&
    clk_src_rc == ($past(instr_word) == `OP_SEL_RC)) else $error("source select bad");
  a_clk_ctrl: assert property (go && instr_word == `OP_WRITE_CLK_CTRL |=>
    clock_control_register == acc_ff ##1 ($stable(clock_control_register) ||
    $past(go && instr_word == `OP_WRITE_CLK_CTRL))) else $error("clock control bad");
endmodule : adc_sys_exec_props

bind adc_sys_exec adc_sys_exec_props i_props (.*);

// >>> test/adc_sys_exec_tb_top.sv
/*
 Directed testbench for the instruction executor.
 Assumes the map header is on the include path and the converter model beside it.
*/
`include "adc_sys_map.svh"
module adc_sys_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [9:0] RES = 10'h2D6;

  logic       clk, rst_n, instr_valid, conv_complete, standby_return_flag, watchdog_expiry;
  logic [9:0] instr_word, conv_result;
  logic [3:0] acc_in, breg_in, interrupt_control_reg_two, acc_wr_data, breg_wr_data;
  logic [3:0] conversion_control_register, clock_control_register;
  logic [7:0] cmp_ref;
  logic       acc_wr_en, breg_wr_en, instr_done, skip_next, conversion_mode_select_bit;
  logic       conv_start, cmp_start, conversion_done_flag, watchdog_expiry_flag;
  logic       watchdog_running, watchdog_restart, backup_state, clk_src_rc, onchip_osc_stopped;
  int         fails, total_checks;

  adc_sys_exec i_dut (.*);
  adc_conv_model #(.RESULT_VAL(RES)) i_conv (.*);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  task automatic issue(input logic [9:0] w, input logic [3:0] a = 4'h0,
                       input logic [3:0] b = 4'h0);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = w;
    acc_in      = a;
    breg_in     = b;
  endtask : issue

  // One word, then idle so its answer is settled on return
  task automatic run(input logic [9:0] w, input logic [3:0] a = 4'h0, input logic [3:0] b = 4'h0);
    issue(w, a, b);
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : run

  task automatic wait_done;
    for (int i = 0; i < 50 && conversion_done_flag !== 1'b1; i++)
      @(negedge clk);
    chk(conversion_done_flag, 1'b1);
    if (conversion_done_flag !== 1'b1)
      final_report();
  endtask : wait_done

  task automatic t_converter;
    run(`OP_WRITE_CONV_CTRL, 4'h8);
    chk(conversion_mode_select_bit, 1'b1);
    run(`OP_READ_CONV_CTRL);
    chk({acc_wr_en, acc_wr_data}, 5'h18);
    run(`OP_WRITE_REF, 4'h5, 4'hA);
    chk(cmp_ref, 8'hA5);
    run(`OP_READ_RESULT);
    chk({breg_wr_data, acc_wr_data}, 8'hA5);
    run(`OP_WRITE_CONV_CTRL, 4'h7);
    chk(conversion_control_register, 4'h7);
    run(`OP_WRITE_REF, 4'hC, 4'h3);
    chk(cmp_ref, 8'hA5);
    run(`OP_READ_RESULT);
    chk({breg_wr_data, acc_wr_data}, RES[9:2]);
    run(`OP_READ_LOW_RESULT);
    chk({breg_wr_en, acc_wr_en, acc_wr_data}, {2'b01, RES[1:0], 2'b00});
  endtask : t_converter

  task automatic t_start_poll;
    run(`OP_CONV_START);
    chk({conv_start, cmp_start}, 2'b10);
    wait_done();
    run(`OP_WRITE_CONV_CTRL, 4'h8);
    run(`OP_CONV_START);
    chk({conv_start, cmp_start, conversion_done_flag}, 3'b010);
    wait_done();
    interrupt_control_reg_two = 4'h4;
    run(`OP_POLL_DONE);
    chk({skip_next, conversion_done_flag}, 2'b01);
    interrupt_control_reg_two = 4'hB;
    run(`OP_POLL_DONE);
    chk({skip_next, conversion_done_flag}, 2'b10);
    run(`OP_POLL_DONE);
    chk(skip_next, 1'b0);
  endtask : t_start_poll

  task automatic t_system;
    run(`OP_NO_OPERATION);
    chk({instr_done, skip_next, acc_wr_en, breg_wr_en}, 4'h8);
    for (int f = 0; f < 2; f++)
    begin
      standby_return_flag = f[0];
      run(`OP_TEST_STANDBY);
      chk(skip_next, f[0]);
    end
    @(negedge clk);
    watchdog_expiry = 1'b1;
    @(negedge clk);
    watchdog_expiry = 1'b0;
    run(`OP_WDT_RESTART);
    chk({skip_next, watchdog_expiry_flag, watchdog_restart}, 3'b101);
    issue(`OP_WDT_STOP_ARM);
    issue(`OP_NO_OPERATION);
    run(`OP_WDT_RESTART);
    chk({skip_next, watchdog_running}, 2'b01);
    issue(`OP_WDT_STOP_ARM);
    run(`OP_WDT_RESTART);
    chk(watchdog_running, 1'b0);
    run(`OP_SEL_RC);
    chk({clk_src_rc, onchip_osc_stopped}, 2'b11);
    run(`OP_SEL_CERAMIC);
    chk({clk_src_rc, onchip_osc_stopped}, 2'b01);
    run(`OP_WRITE_CLK_CTRL, 4'h6);
    run(`OP_READ_CLK_CTRL);
    chk({clock_control_register, acc_wr_data}, 8'h66);
  endtask : t_system

  task automatic t_backup;
    run(`OP_BACKUP_ENTER);
    chk(backup_state, 1'b0);
    issue(`OP_BACKUP_ARM);
    issue(`OP_NO_OPERATION);
    run(`OP_BACKUP_ENTER);
    chk(backup_state, 1'b0);
    issue(`OP_BACKUP_ARM);
    run(10'h3FF);
    chk({instr_done, acc_wr_en, skip_next}, 3'h0);
    run(`OP_BACKUP_ENTER);
    chk(backup_state, 1'b0);
    issue(`OP_BACKUP_ARM);
    run(`OP_BACKUP_ENTER);
    chk(backup_state, 1'b1);
    run(`OP_NO_OPERATION);
    chk(instr_done, 1'b0);
  endtask : t_backup

  // Mid-run reset leaves the halted state; checks backup, watchdog, oscillator stop and converter control
  task automatic t_reset;
    rst_n = 1'b0;
    @(negedge clk);
    chk({backup_state, watchdog_running, onchip_osc_stopped, conversion_control_register}, 7'h20);
    rst_n = 1'b1;
    run(`OP_NO_OPERATION);
    chk(instr_done, 1'b1);
  endtask : t_reset

  initial
  begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 10'h000;
    acc_in = 4'h0;
    breg_in = 4'h0;
    interrupt_control_reg_two = 4'h0;
    standby_return_flag = 1'b0;
    watchdog_expiry = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk({watchdog_running, backup_state, conversion_done_flag}, 3'b100);
    t_converter();
    t_start_poll();
    t_system();
    t_backup();
    t_reset();
    final_report();
  end
endmodule : adc_sys_exec_tb_top
